/* File: cfsr_top.sv */
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none

module cfsr_top #(
    parameter int unsigned                      register_width     = 8,
    parameter cfsr_pkg::cfsr_variant_e          variant            = cfsr_pkg::VARIANT_MULTI,
    parameter logic [register_width-1:0]        power_on_value     = '0,
    parameter logic [register_width-1:0]        async_clear_value  = '0,
    parameter logic [register_width-1:0]        async_preset_value = '1,
    parameter logic [register_width-1:0]        sync_clear_value   = '0,
    parameter logic [register_width-1:0]        sync_preset_value  = '1,
    parameter cfsr_pkg::cfsr_edge_e             clock_edge_select  = cfsr_pkg::EDGE_RISE,
    parameter logic                             load_level         = 1'b1,
    parameter logic                             left_level         = 1'b1,
    parameter logic                             set_reset_level    = 1'b1
) (
    input  wire logic                           core_clk_i,
    input  wire logic                           rst_n_i,
    // APB slave
    input  wire logic [cfsr_pkg::APB_ADDR_W-1:0] paddr_i,
    input  wire logic                           psel_i,
    input  wire logic                           penable_i,
    input  wire logic                           pwrite_i,
    input  wire logic [cfsr_pkg::APB_DATA_W-1:0] pwdata_i,
    input  wire logic [3:0]                     pstrb_i,
    output logic                                pready_o,
    output logic      [cfsr_pkg::APB_DATA_W-1:0] prdata_o,
    output logic                                pslverr_o,
    // Shift register pins
    input  wire cfsr_pkg::cfsr_pins_s           pins_i,
    input  wire logic [register_width-1:0]      par_data_i,
    output logic      [register_width-1:0]      par_data_o
);
    import cfsr_pkg::*;

    localparam logic [register_width-1:0] W_ZERO = '0;
    localparam cfsr_ctrl_s CTRL_RESET = '{sr_level:   set_reset_level,
                                          left_level: left_level,
                                          load_level: load_level,
                                          edge_sel:   clock_edge_select};
    // Pins rest in their inactive level so reset does not look like a clear
    localparam cfsr_pins_s PINS_RESET = '{shift_clk:    1'b0,
                                          serial_in:    1'b0,
                                          load_ctl:     1'b0,
                                          dir_ctl:      1'b0,
                                          async_clear:  ~set_reset_level,
                                          async_preset: ~set_reset_level,
                                          sync_clear:   ~set_reset_level,
                                          sync_preset:  ~set_reset_level};

    // ======================================================================
    // Helpers
    // Compare a pin with its configured active level
    function automatic logic level_hit(input logic pin, input logic level);
        level_hit = (pin == level);
    endfunction : level_hit

    // One-place shift with the serial bit filling the vacated end
    function automatic logic [register_width-1:0] shift_one(
        input logic [register_width-1:0] value,
        input logic                      to_left,
        input logic                      fill);
        if (to_left) begin
            shift_one = {value[register_width-2:0], fill};
        end else begin
            shift_one = {fill, value[register_width-1:1]};
        end
    endfunction : shift_one

    // ======================================================================
    // Pin synchronisers
    logic [PINS_W-1:0]         pins_raw;
    cfsr_pins_s                pins_sync;
    logic [register_width-1:0] par_sync;

    assign pins_raw = pins_i;

    cfsr_sync2 #(
        .width       (PINS_W),
        .reset_value (PINS_RESET)
    ) u_pin_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .async_i    (pins_raw),
        .sync_o     (pins_sync)
    );

    // Parallel data needs no special rest value
    cfsr_sync2 #(
        .width       (register_width),
        .reset_value (W_ZERO)
    ) u_data_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .async_i    (par_data_i),
        .sync_o     (par_sync)
    );

    // ======================================================================
    // Control register state
    cfsr_ctrl_s                ctrl_reg;
    cfsr_ctrl_s                ctrl_next;
    logic                      shclk_prev_reg;
    logic                      shclk_prev_next;

    // ======================================================================
    // Decoded actions
    logic trig_edge;
    logic async_clr;
    logic async_pre;
    logic sync_clr;
    logic sync_pre;
    logic load_now;
    logic go_left;

    always_comb begin
        // Edge detect on the synchronised pin; costs two cycles of latency
        trig_edge = (pins_sync.shift_clk != shclk_prev_reg) &&
                    (pins_sync.shift_clk == (ctrl_reg.edge_sel == EDGE_RISE));
        async_clr = level_hit(pins_sync.async_clear,  ctrl_reg.sr_level);
        async_pre = level_hit(pins_sync.async_preset, ctrl_reg.sr_level);
        sync_clr  = level_hit(pins_sync.sync_clear,   ctrl_reg.sr_level);
        sync_pre  = level_hit(pins_sync.sync_preset,  ctrl_reg.sr_level);
        load_now  = (pins_sync.load_ctl == ctrl_reg.load_level);
        // Fixed variants ignore the direction pin
        case (variant)
            VARIANT_LEFT:  go_left = 1'b1;
            VARIANT_RIGHT: go_left = 1'b0;
            default:       go_left = (pins_sync.dir_ctl == ctrl_reg.left_level);
        endcase
    end

    // ======================================================================
    // Shift register core
    logic [register_width-1:0] shift_reg;
    logic [register_width-1:0] shift_next;

    // Async terms act without waiting for an edge, clear ahead of preset
    always_comb begin
        shift_next      = shift_reg;
        shclk_prev_next = pins_sync.shift_clk;
        if (async_clr) begin
            shift_next = async_clear_value;
        end else if (async_pre) begin
            shift_next = async_preset_value;
        end else if (trig_edge) begin
            if (sync_clr) begin
                shift_next = sync_clear_value;
            end else if (sync_pre) begin
                shift_next = sync_preset_value;
            end else if (load_now) begin
                shift_next = par_sync;
            end else begin
                shift_next = shift_one(shift_reg, go_left, pins_sync.serial_in);
            end
        end
    end

    // Start from the power-on value until the first event
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_reg      <= power_on_value;
            shclk_prev_reg <= PINS_RESET.shift_clk;
        end else begin
            shift_reg      <= shift_next;
            shclk_prev_reg <= shclk_prev_next;
        end
    end

    assign par_data_o = shift_reg;

    // ======================================================================
    // APB slave: one access-phase cycle, answer prepared in setup
    logic                  pready_reg;
    logic                  pready_next;
    logic [APB_DATA_W-1:0] prdata_reg;
    logic [APB_DATA_W-1:0] prdata_next;
    logic                  pslverr_reg;
    logic                  pslverr_next;
    logic                  setup_ph;
    logic                  wr_done;

    assign setup_ph = psel_i && !penable_i;
    assign wr_done  = psel_i && penable_i && pready_reg && pwrite_i;

    always_comb begin
        pready_next  = setup_ph;
        prdata_next  = READ_ZERO;
        pslverr_next = 1'b0;
        ctrl_next    = ctrl_reg;
        if (setup_ph && !pwrite_i) begin
            if (paddr_i == CTRL_OFFSET) begin
                prdata_next = {{(APB_DATA_W-CTRL_W){1'b0}}, ctrl_reg};
            end else if (paddr_i == VALUE_OFFSET) begin
                prdata_next = APB_DATA_W'(shift_reg);
            end else if (paddr_i == PINS_OFFSET) begin
                prdata_next = {{(APB_DATA_W-PINS_W){1'b0}}, pins_sync};
            end else begin
                pslverr_next = 1'b1;
            end
        end else if (setup_ph) begin
            // Value and pin words are read-only; writes there are dropped
            pslverr_next = !((paddr_i == CTRL_OFFSET) || (paddr_i == VALUE_OFFSET) ||
                             (paddr_i == PINS_OFFSET));
        end
        // Configuration changes land at the access-phase completion edge
        if (wr_done && (paddr_i == CTRL_OFFSET) && pstrb_i[CTRL_STRB]) begin
            ctrl_next = cfsr_ctrl_s'(pwdata_i[CTRL_W-1:0]);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= READ_ZERO;
            pslverr_reg <= 1'b0;
            ctrl_reg    <= CTRL_RESET;
        end else begin
            pready_reg  <= pready_next;
            prdata_reg  <= prdata_next;
            pslverr_reg <= pslverr_next;
            ctrl_reg    <= ctrl_next;
        end
    end

    assign pready_o  = pready_reg;
    assign prdata_o  = prdata_reg;
    assign pslverr_o = pslverr_reg;

    // ======================================================================
    // Checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    logic any_event;
    assign any_event = trig_edge || async_clr || async_pre;

    edge_only_hold_a: assert property (
        !any_event |=> $stable(shift_reg))
        else $error("value changed without trigger edge or async event");

    load_polarity_a: assert property (
        trig_edge && !async_clr && !async_pre && !sync_clr && !sync_pre &&
        (pins_sync.load_ctl == ctrl_reg.load_level)
        |=> shift_reg == $past(par_sync))
        else $error("parallel load did not capture data");

    dir_polarity_a: assert property (
        (variant == VARIANT_MULTI) && trig_edge && !async_clr && !async_pre &&
        !sync_clr && !sync_pre && !load_now && (pins_sync.dir_ctl == ctrl_reg.left_level)
        |=> shift_reg == {$past(shift_reg[register_width-2:0]), $past(pins_sync.serial_in)})
        else $error("left shift on direction level failed");

    async_clear_a: assert property (
        (pins_sync.async_clear == ctrl_reg.sr_level) |=> shift_reg == async_clear_value)
        else $error("async clear did not take effect");

    async_preset_a: assert property (
        (pins_sync.async_preset == ctrl_reg.sr_level) &&
        (pins_sync.async_clear != ctrl_reg.sr_level) |=> shift_reg == async_preset_value)
        else $error("async preset did not take effect");

    sync_clear_a: assert property (
        trig_edge && !async_clr && !async_pre && sync_clr
        |=> shift_reg == sync_clear_value)
        else $error("sync clear at edge failed");

    sync_preset_a: assert property (
        trig_edge && !async_clr && !async_pre && !sync_clr && sync_pre
        |=> shift_reg == sync_preset_value)
        else $error("sync preset at edge failed");

    right_fill_a: assert property (
        (variant == VARIANT_RIGHT) && trig_edge && !async_clr && !async_pre &&
        !sync_clr && !sync_pre && !load_now
        |=> shift_reg == {$past(pins_sync.serial_in), $past(shift_reg[register_width-1:1])})
        else $error("right shift fill wrong");

    apb_answer_a: assert property (
        setup_ph |=> pready_o ##1 !pready_o || (psel_i && !penable_i))
        else $error("apb answer not a single cycle");

    load_seen_c:   cover property (trig_edge && load_now && !sync_clr && !sync_pre);
    shift_seen_c:  cover property (trig_edge && !load_now && !sync_clr && !sync_pre);
    async_seen_c:  cover property (async_clr && trig_edge && sync_pre);
    ctrl_write_c:  cover property (wr_done && (paddr_i == CTRL_OFFSET));

endmodule : cfsr_top

`default_nettype wire

/* File: cfsr_pkg.sv */
// ==========================================================================
// Shared constants and carriers for the configurable shift register
package cfsr_pkg;

    // ======================================================================
    // Bus geometry
    localparam int unsigned APB_ADDR_W = 12;
    localparam int unsigned APB_DATA_W = 32;

    // ======================================================================
    // Register byte offsets
    localparam logic [APB_ADDR_W-1:0] CTRL_OFFSET  = 12'h000;
    localparam logic [APB_ADDR_W-1:0] VALUE_OFFSET = 12'h004;
    localparam logic [APB_ADDR_W-1:0] PINS_OFFSET  = 12'h008;

    // ======================================================================
    // Field positions and widths
    localparam int unsigned CTRL_W      = 4;
    localparam int unsigned PINS_W      = 8;
    localparam int unsigned CTRL_STRB   = 0;
    localparam logic [APB_DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    // ======================================================================
    // Clock edge on which the register acts
    typedef enum logic [0:0] {
        EDGE_RISE = 1'b0,                      // Low to high
        EDGE_FALL = 1'b1                       // High to low
    } cfsr_edge_e;

    // Shift direction variant fixed at build time
    typedef enum logic [1:0] {
        VARIANT_LEFT  = 2'b00,
        VARIANT_RIGHT = 2'b01,
        VARIANT_MULTI = 2'b10
    } cfsr_variant_e;

    // ======================================================================
    // Control word, bit 0 upward: edge, load level, left level, set/reset level
    typedef struct packed {
        logic       sr_level;
        logic       left_level;
        logic       load_level;
        cfsr_edge_e edge_sel;
    } cfsr_ctrl_s;

    // Single-bit control pins from the surrounding logic
    typedef struct packed {
        logic shift_clk;
        logic serial_in;
        logic load_ctl;
        logic dir_ctl;
        logic async_clear;
        logic async_preset;
        logic sync_clear;
        logic sync_preset;
    } cfsr_pins_s;

endpackage : cfsr_pkg

/* File: cfsr_sync2.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Two-stage synchroniser for pins arriving from outside the clock domain
module cfsr_sync2 #(
    parameter int unsigned         width       = 1,
    parameter logic [width-1:0]    reset_value = '0
) (
    input  wire logic              core_clk_i,
    input  wire logic              rst_n_i,
    input  wire logic [width-1:0]  async_i,
    output logic      [width-1:0]  sync_o
);

    logic [width-1:0] meta_reg;
    logic [width-1:0] sync_reg;

    // The first stage feeds only the second; nothing else may look at it
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg <= reset_value;
            sync_reg <= reset_value;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule : cfsr_sync2

`default_nettype wire

/* File: cfsr_far_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Surrounding logic that drives the shift register pins
module cfsr_far_model (
    input  wire logic                 core_clk_i,
    output var  cfsr_pkg::cfsr_pins_s pins_o,
    output var  logic [7:0]           par_data_o
);
    import cfsr_pkg::*;

    // All low at start: inactive while set/reset is active high
    initial begin
        pins_o     = '0;
        par_data_o = 8'h00;
    end

    // New levels land just after a rising edge, never on the falling one
    task automatic drive(input cfsr_pins_s p, input logic [7:0] d);
        @(posedge core_clk_i);
        pins_o     <= p;
        par_data_o <= d;
    endtask : drive

    // Four cycles each way, so the sampled clock pin never loses a phase
    task automatic pulse();
        @(posedge core_clk_i);
        pins_o.shift_clk <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        pins_o.shift_clk <= 1'b0;
        repeat (4) @(posedge core_clk_i);
    endtask : pulse

endmodule : cfsr_far_model

`default_nettype wire

/* File: tb_configurable_shift_register.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Bench: APB tasks plus pin sequences through the far-side model
module tb_configurable_shift_register;
    import cfsr_pkg::*;

    logic        core_clk_i = 1'b0;
    logic        rst_n_i    = 1'b0;
    logic [11:0] paddr      = 12'h000;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [31:0] pwdata     = 32'h0000_0000;
    logic [3:0]  pstrb      = 4'h0;
    wire  logic        pready;
    wire  logic        pslverr;
    wire  logic [31:0] prdata;
    cfsr_pins_s  pins;
    logic [7:0]  par_d;
    wire  logic [7:0]  q;
    wire  logic [5:0]  q_r;
    wire  logic [3:0]  q_l;
    logic [31:0] rd;
    logic        err;
    int          errors      = 0;
    int          comparisons = 0;
    int          cycles      = 0;

    // ======================================================================
    // Clock, reset and hang guard
    initial begin
        forever #25 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            stop_test();
        end
    end

    // ======================================================================
    // Build values for the instances, each used by one of them; the expected values in the checks below are written out as literals
    localparam int unsigned W_MAIN    = 8;
    localparam int unsigned W_RIGHT   = 6;
    localparam int unsigned W_LEFT    = 4;
    localparam logic [7:0]  PON_MAIN  = 8'h5a;
    localparam logic [7:0]  ACLR_MAIN = 8'h11;
    localparam logic [7:0]  APRE_MAIN = 8'hee;
    localparam logic [7:0]  SCLR_MAIN = 8'h22;
    localparam logic [7:0]  SPRE_MAIN = 8'hdd;
    localparam logic [5:0]  PON_RIGHT = 6'h2a;
    localparam logic [3:0]  PON_LEFT  = 4'h9;

    // Main instance plus narrow right-only and left-only ones sharing bus and pins
    cfsr_top #(.register_width(W_MAIN), .power_on_value(PON_MAIN),
        .async_clear_value(ACLR_MAIN), .async_preset_value(APRE_MAIN),
        .sync_clear_value(SCLR_MAIN), .sync_preset_value(SPRE_MAIN))
    dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .pins_i(pins),
        .par_data_i(par_d), .par_data_o(q));
    cfsr_top #(.register_width(W_RIGHT), .variant(VARIANT_RIGHT), .power_on_value(PON_RIGHT))
    dut_r_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .pready_o(), .prdata_o(), .pslverr_o(), .pins_i(pins),
        .par_data_i(par_d[5:0]), .par_data_o(q_r));
    cfsr_top #(.register_width(W_LEFT), .variant(VARIANT_LEFT), .power_on_value(PON_LEFT))
    dut_l_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .pready_o(), .prdata_o(), .pslverr_o(), .pins_i(pins),
        .par_data_i(par_d[3:0]), .par_data_o(q_l));
    cfsr_far_model far_u (.core_clk_i(core_clk_i), .pins_o(pins), .par_data_o(par_d));

    // ======================================================================
    // Tasks
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge core_clk_i);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge core_clk_i);
        penable <= 1'b1;
        // No wait count assumed: only the bench cycle ceiling ends a stuck wait
        do begin
            @(posedge core_clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, 4'hf);
        check("read data", rd, e);
    endtask : rdchk

    task automatic qchk(input logic [7:0] e, input logic [5:0] er);
        check("value", {24'h0, q}, {24'h0, e});
        check("right value", {26'h0, q_r}, {26'h0, er});
    endtask : qchk

    // Left-only variant ignores the direction pin
    task automatic lchk(input logic [3:0] e);
        check("left value", {28'h0, q_l}, {28'h0, e});
    endtask : lchk

    // Pin bits: clk, serial, load, dir, async clr, async set, sync clr, sync set
    task automatic pin(input logic [7:0] p, input logic [7:0] d);
        far_u.drive(cfsr_pins_s'(p), d);
    endtask : pin

    task automatic stop_test();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    // ======================================================================
    // Sequence
    initial begin
        repeat (10) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        qchk(8'h5a, 6'h2a);
        lchk(4'h9);
        rdchk(CTRL_OFFSET, 32'h0000_000e);
        apb(1'b1, CTRL_OFFSET, 32'h0000_0000, 4'h0);
        apb(1'b1, VALUE_OFFSET, 32'h0000_00ff, 4'hf);
        check("value write error", {31'h0, err}, 32'h0000_0000);
        rdchk(CTRL_OFFSET, 32'h0000_000e);
        rdchk(VALUE_OFFSET, 32'h0000_005a);
        apb(1'b0, 12'h00c, 32'h0000_0000, 4'hf);
        check("unmapped data", rd, 32'h0000_0000);
        check("unmapped error", {31'h0, err}, 32'h0000_0001);
        // Load, then shift both ways with the default polarities
        pin(8'h20, 8'hc3);
        far_u.pulse();
        qchk(8'hc3, 6'h03);
        lchk(4'h3);
        pin(8'h50, 8'hc3);
        far_u.pulse();
        qchk(8'h87, 6'h21);
        lchk(4'h7);
        pin(8'h00, 8'hc3);
        far_u.pulse();
        qchk(8'h43, 6'h10);
        lchk(4'he);
        // Load and direction polarities swapped
        apb(1'b1, CTRL_OFFSET, 32'h0000_0008, 4'hf);
        rdchk(CTRL_OFFSET, 32'h0000_0008);
        pin(8'h00, 8'h96);
        far_u.pulse();
        qchk(8'h96, 6'h16);
        pin(8'h70, 8'h96);
        far_u.pulse();
        qchk(8'hcb, 6'h2b);
        lchk(4'hd);
        pin(8'h20, 8'h96);
        far_u.pulse();
        qchk(8'h96, 6'h15);
        // Falling edge selected: the rise must do nothing
        apb(1'b1, CTRL_OFFSET, 32'h0000_0009, 4'hf);
        pin(8'h80, 8'h5c);
        repeat (5) @(posedge core_clk_i);
        qchk(8'h96, 6'h15);
        pin(8'h00, 8'h5c);
        repeat (5) @(posedge core_clk_i);
        qchk(8'h5c, 6'h1c);
        // Sync clear and preset over load, clear over preset
        apb(1'b1, CTRL_OFFSET, 32'h0000_000e, 4'hf);
        pin(8'h22, 8'h77);
        far_u.pulse();
        qchk(8'h22, 6'h00);
        lchk(4'h0);
        pin(8'h21, 8'h77);
        far_u.pulse();
        qchk(8'hdd, 6'h3f);
        pin(8'h23, 8'h77);
        far_u.pulse();
        qchk(8'h22, 6'h00);
        pin(8'h20, 8'h77);
        far_u.pulse();
        qchk(8'h77, 6'h37);
        // Async terms act without a clock and beat a load
        pin(8'h28, 8'h77);
        repeat (5) @(posedge core_clk_i);
        qchk(8'h11, 6'h00);
        far_u.pulse();
        qchk(8'h11, 6'h00);
        rdchk(VALUE_OFFSET, 32'h0000_0011);
        pin(8'h24, 8'h77);
        repeat (5) @(posedge core_clk_i);
        qchk(8'hee, 6'h3f);
        pin(8'h2c, 8'h77);
        repeat (5) @(posedge core_clk_i);
        qchk(8'h11, 6'h00);
        // Active-low set/reset: high pins are idle, a low one acts
        pin(8'h2f, 8'h3c);
        apb(1'b1, CTRL_OFFSET, 32'h0000_0006, 4'hf);
        far_u.pulse();
        qchk(8'h3c, 6'h3c);
        rdchk(PINS_OFFSET, 32'h0000_002f);
        pin(8'h2b, 8'h3c);
        repeat (5) @(posedge core_clk_i);
        qchk(8'hee, 6'h3f);
        stop_test();
    end

endmodule : tb_configurable_shift_register

`default_nettype wire
